// file: core/asr_defs.vh
// Constants of the alarm and status reporter.
// Assumes inclusion by its bare name from core/ design files.
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH

// Fault input bit positions
`define ASR_F_OC_RUN    0
`define ASR_F_OC_REGEN  1
`define ASR_F_OC_CHG    2
`define ASR_F_OC_DIS    3
`define ASR_F_CTL_LOW   4
`define ASR_F_LINK_OV   5
`define ASR_F_CAP_OV    6
`define ASR_F_CAP_UV    7
`define ASR_F_HS_HOT    8
`define ASR_F_RES_HOT   9
`define ASR_F_PSU_ALM   10
`define ASR_F_COMM_ERR  11
`define ASR_F_NO_CHG    12
`define ASR_F_NO_DIS    13
`define ASR_F_BAD_DIS   14
`define ASR_F_CC_FAIL   15
`define ASR_F_FUSE      16
`define ASR_F_FAN_STOP  17
`define ASR_F_CAP_DIFF  18
`define ASR_NFAULT      19
// Faults 0..5 are serious
`define ASR_NSERIOUS    6

// Display character codes
`define ASR_CH_DASH     5'h00
`define ASR_CH_ZERO     5'h01
`define ASR_CH_CW       5'h02
`define ASR_CH_CCW      5'h03
`define ASR_CH_1        5'h04
`define ASR_CH_2        5'h05
`define ASR_CH_3        5'h06
`define ASR_CH_4        5'h07
`define ASR_CH_5        5'h08
`define ASR_CH_6        5'h09
`define ASR_CH_7        5'h0a
`define ASR_CH_8        5'h0b
`define ASR_CH_9        5'h0c
`define ASR_CH_J        5'h0d
`define ASR_CH_C        5'h0e
`define ASR_CH_P        5'h0f
`define ASR_CH_E        5'h10
`define ASR_CH_F        5'h11
`define ASR_CH_H        5'h12
`define ASR_CH_LB       5'h13
`define ASR_CH_LH       5'h14
`define ASR_CH_A        5'h15
`define ASR_CH_U        5'h16

// Rotation animation step, ms, at 40 MHz
`define ASR_ROT_MS      100
`define ASR_CLK_KHZ     40000
`define ASR_ROT_CYC     (`ASR_ROT_MS * `ASR_CLK_KHZ)

`endif

// file: core/asr_sync.v
// Per-bit three-flop input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes when stages 2 and 3 agree.
`timescale 1ns/100ps
`default_nettype none
module asr_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clock,
    input wire rstn,
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            reg s1_q, s2_q, s3_q, o_q;
            always @(posedge clock)
            begin
                if (!rstn)
                begin
                    s1_q <= INIT[i];
                    s2_q <= INIT[i];
                    s3_q <= INIT[i];
                    o_q <= INIT[i];
                end
                else
                begin
                    s1_q <= din[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        o_q <= s3_q;
                end
            end
            assign dout[i] = o_q;
        end
    endgenerate
endmodule
`default_nettype wire

// file: core/asr_reporter.v
// Alarm and status reporter of the energy charge unit: display code,
// severity pair to the machine logic controller, energy path cut.
// Assumes fault and state inputs are asynchronous pins from the unit.
// Outputs follow a settled fault or clear pin change six clock edges later, a ready, charging or discharging pin change five.
`timescale 1ns/100ps
`default_nettype none
`include "asr_defs.vh"
// Notes on behaviour
// - Any alarm halts supply, cuts amplifier path
// - Display dash, 0, cw or ccw rotation
// - Alarms 1, 2 on link over-current
// - Alarms 3, 4 on bank current excess
// - Alarm 5 low 24V, 6 link over-voltage
// - Alarms 7, 8 bank over/under-voltage
// - Alarm 9 heat-sink, J resistor thermostat
// - Alarm C supply alarm, P comm error
// - Alarms E, F, H on charge/discharge faults
// - Alarm b current control, h fuse
// - Fan stop: warning A, keep running
// - Bank difference over 300V: U, stop supply
// - Alarm drops low severity bit to controller
// - HH normal, HL abnormal, LL serious
// - Alarms 1-6 LL, others and warnings HL
// - Two-bit status pair on discrete outputs
module asr_reporter #(
    parameter ROT_CYC = `ASR_ROT_CYC
) (
    input wire clock,
    input wire rstn,
    input wire [`ASR_NFAULT-1:0] fault_in,
    input wire unit_ready,
    input wire charging,
    input wire discharging,
    input wire fault_clear,
    output reg [4:0] disp_char_q,
    output reg [2:0] rot_phase_q,
    output reg severity_bit_high,
    output reg severity_bit_low,
    output reg supply_enable_q,
    output reg path_connect_q
);
    wire [`ASR_NFAULT-1:0] fault_s;
    wire [3:0] st_s;

    asr_sync #(.W(`ASR_NFAULT)) u_sync_f (
        .clock(clock),
        .rstn(rstn),
        .din(fault_in),
        .dout(fault_s)
    );

    asr_sync #(.W(4)) u_sync_s (
        .clock(clock),
        .rstn(rstn),
        .din({fault_clear, discharging, charging, unit_ready}),
        .dout(st_s)
    );

    // Filtered state pins
    wire st_ready = st_s[0];
    wire st_chg = st_s[1];
    wire st_dis = st_s[2];
    wire st_clear = st_s[3];

    // Latched faults; a fault present while clearing stays latched
    reg [`ASR_NFAULT-1:0] latch_q;
    reg [`ASR_NFAULT-1:0] latch_d;
    always @*
    begin
        latch_d = latch_q | fault_s;
        if (st_clear)
            latch_d = fault_s;
    end

    // Severity classes of the latched faults
    wire alarm_any = |latch_q[`ASR_F_FUSE:0];
    wire serious = |latch_q[`ASR_NSERIOUS-1:0];
    wire warn_any = latch_q[`ASR_F_FAN_STOP] | latch_q[`ASR_F_CAP_DIFF];

    // Lowest index wins when several are latched
    reg [4:0] char_d;
    always @*
    begin
        char_d = `ASR_CH_DASH;
        if (st_ready)
            char_d = `ASR_CH_ZERO;
        if (st_chg)
            char_d = `ASR_CH_CW;
        if (st_dis)
            char_d = `ASR_CH_CCW;
        if (latch_q[`ASR_F_CAP_DIFF])
            char_d = `ASR_CH_U;
        if (latch_q[`ASR_F_FAN_STOP])
            char_d = `ASR_CH_A;
        if (latch_q[`ASR_F_FUSE])
            char_d = `ASR_CH_LH;
        if (latch_q[`ASR_F_CC_FAIL])
            char_d = `ASR_CH_LB;
        if (latch_q[`ASR_F_BAD_DIS])
            char_d = `ASR_CH_H;
        if (latch_q[`ASR_F_NO_DIS])
            char_d = `ASR_CH_F;
        if (latch_q[`ASR_F_NO_CHG])
            char_d = `ASR_CH_E;
        if (latch_q[`ASR_F_COMM_ERR])
            char_d = `ASR_CH_P;
        if (latch_q[`ASR_F_PSU_ALM])
            char_d = `ASR_CH_C;
        if (latch_q[`ASR_F_RES_HOT])
            char_d = `ASR_CH_J;
        if (latch_q[`ASR_F_HS_HOT])
            char_d = `ASR_CH_9;
        if (latch_q[`ASR_F_CAP_UV])
            char_d = `ASR_CH_8;
        if (latch_q[`ASR_F_CAP_OV])
            char_d = `ASR_CH_7;
        if (latch_q[`ASR_F_LINK_OV])
            char_d = `ASR_CH_6;
        if (latch_q[`ASR_F_CTL_LOW])
            char_d = `ASR_CH_5;
        if (latch_q[`ASR_F_OC_DIS])
            char_d = `ASR_CH_4;
        if (latch_q[`ASR_F_OC_CHG])
            char_d = `ASR_CH_3;
        if (latch_q[`ASR_F_OC_REGEN])
            char_d = `ASR_CH_2;
        if (latch_q[`ASR_F_OC_RUN])
            char_d = `ASR_CH_1;
    end

    // Rotation phase steps only while a rotating pattern is shown
    reg [31:0] rot_cnt_q;
    reg [31:0] rot_cnt_d;
    reg [2:0] rot_phase_d;
    wire rotating = (char_d == `ASR_CH_CW) || (char_d == `ASR_CH_CCW);
    wire rot_tick = (rot_cnt_q == ROT_CYC - 1);

    // Counter idles at zero, so a first step lasts a full period
    always @*
    begin
        rot_cnt_d = rot_cnt_q + 32'h1;
        rot_phase_d = rot_phase_q;
        if (!rotating || rot_tick)
            rot_cnt_d = 32'h0;
        if (rotating && rot_tick)
        begin
            if (char_d == `ASR_CH_CW)
                rot_phase_d = rot_phase_q + 3'h1;
            else
                rot_phase_d = rot_phase_q - 3'h1;
        end
    end

    // Pair falls only from latched state so it stays settled
    reg sev_high_d;
    reg sev_low_d;
    reg supply_d;
    reg path_d;
    always @*
    begin
        sev_high_d = ~serious;
        sev_low_d = ~(alarm_any | warn_any);
        // Fan stop alone keeps supply running
        supply_d = st_ready & ~alarm_any;
        if (latch_q[`ASR_F_CAP_DIFF])
            supply_d = 1'b0;
        // Warnings never open the path to the amplifier
        path_d = st_ready & ~alarm_any;
    end

    // Reset shows not ready with a normal pair
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            latch_q <= {`ASR_NFAULT{1'b0}};
            disp_char_q <= `ASR_CH_DASH;
        end
        else
        begin
            latch_q <= latch_d;
            disp_char_q <= char_d;
        end
    end

    // Phase wraps freely; only its direction of travel is shown
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            rot_cnt_q <= 32'h0;
            rot_phase_q <= 3'h0;
        end
        else
        begin
            rot_cnt_q <= rot_cnt_d;
            rot_phase_q <= rot_phase_d;
        end
    end

    // Supply and path start off until the unit reports ready
    always @(posedge clock)
    begin
        if (!rstn)
        begin
            severity_bit_high <= 1'b1;
            severity_bit_low <= 1'b1;
            supply_enable_q <= 1'b0;
            path_connect_q <= 1'b0;
        end
        else
        begin
            severity_bit_high <= sev_high_d;
            severity_bit_low <= sev_low_d;
            supply_enable_q <= supply_d;
            path_connect_q <= path_d;
        end
    end
endmodule
`default_nettype wire

// file: tb/asr_plc_model.sv
// Controller model that reads the severity pair over discrete inputs.
// Assumes pull-down inputs: an open cable reads low on both bits.
`timescale 1ns/100ps
`default_nettype none
module asr_plc_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic sev_hi,
    input wire logic sev_lo,
    input wire logic cable_ok,
    output logic park_q,
    output logic estop_q
);
    logic lo_q;
    wire hi = sev_hi & cable_ok;
    wire lo = sev_lo & cable_ok;
    always @(posedge clock)
    begin
        if (!rstn || (hi && lo))
        begin
            lo_q <= 1'b1;
            park_q <= 1'b0;
            estop_q <= 1'b0;
        end
        else
        begin
            lo_q <= lo;
            // High bit read only at the fall of the low bit
            if (lo_q && !lo)
                park_q <= hi;
            if (lo_q && !lo && !hi)
                estop_q <= 1'b1;
            if (park_q)
                estop_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: tb/asr_checker.sv
// Checker of status pair, display code and energy path cut.
// Assumes a bind to asr_reporter with its six-edge input delay.
`timescale 1ns/100ps
`default_nettype none
`include "asr_defs.vh"
module asr_checker #(
    parameter ROT_CYC = 4
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [`ASR_NFAULT-1:0] fault_in,
    input wire logic unit_ready,
    input wire logic fault_clear,
    input wire logic [4:0] disp_char_q,
    input wire logic [2:0] rot_phase_q,
    input wire logic severity_bit_high,
    input wire logic severity_bit_low,
    input wire logic supply_enable_q,
    input wire logic path_connect_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_low_drops: assert property ((|fault_in)[*6] |=> !severity_bit_low)
        else $error("low bit not dropped");
    a_serious_high: assert property (
        (|fault_in[5:0])[*6] |=> !severity_bit_high)
        else $error("serious alarm left high bit up");
    a_low_cause: assert property (
        $fell(severity_bit_low) |-> $past(|fault_in, 6))
        else $error("low bit fell without a fault");
    a_supply_cut: assert property (
        (|fault_in[16:0] || fault_in[18])[*6] |=> !supply_enable_q)
        else $error("supply kept on during alarm");
    a_path_cut: assert property (
        (|fault_in[16:0])[*6] |=> !path_connect_q)
        else $error("path kept closed during alarm");
    a_phase_still: assert property ($changed(rot_phase_q) |->
        (disp_char_q == `ASR_CH_CW || disp_char_q == `ASR_CH_CCW))
        else $error("phase stepped while not rotating");
    a_fan_keeps: assert property (
        (unit_ready && fault_in == 19'h20000)[*6] ##0
        (path_connect_q && supply_enable_q) |=> path_connect_q)
        else $error("fan stop opened the path");
    a_code_one: assert property (
        fault_in[0][*6] |=> disp_char_q == `ASR_CH_1)
        else $error("code 1 not shown");
    a_pair_holds: assert property (
        (!fault_clear)[*6] ##0 !severity_bit_low |=> !severity_bit_low)
        else $error("pair released without clear");
endmodule
bind asr_reporter asr_checker #(.ROT_CYC(ROT_CYC)) asr_checker_inst (.clock,
    .rstn, .fault_in, .unit_ready, .fault_clear, .disp_char_q, .rot_phase_q,
    .severity_bit_high, .severity_bit_low, .supply_enable_q, .path_connect_q);
`default_nettype wire

// file: tb/tb.sv
// Testbench of the alarm and status reporter with a controller model.
// Assumes short rotation steps; inputs settle within eight cycles.
`timescale 1ns/100ps
`default_nettype none
`include "asr_defs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [18:0] fault_in = 19'h0;
    logic unit_ready = 1'b0;
    logic charging = 1'b0;
    logic discharging = 1'b0;
    logic fault_clear = 1'b0;
    logic cable_ok = 1'b1;
    wire [4:0] disp;
    wire hi, lo, sup, path, estop;
    wire [2:0] rot;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [4:0] exp_ch [19] = '{`ASR_CH_1, `ASR_CH_2, `ASR_CH_3, `ASR_CH_4,
        `ASR_CH_5, `ASR_CH_6, `ASR_CH_7, `ASR_CH_8, `ASR_CH_9, `ASR_CH_J,
        `ASR_CH_C, `ASR_CH_P, `ASR_CH_E, `ASR_CH_F, `ASR_CH_H, `ASR_CH_LB,
        `ASR_CH_LH, `ASR_CH_A, `ASR_CH_U};
    asr_reporter #(.ROT_CYC(4)) asr_reporter_inst (.clock, .rstn, .fault_in,
        .unit_ready, .charging, .discharging, .fault_clear,
        .disp_char_q(disp), .rot_phase_q(rot), .severity_bit_high(hi),
        .severity_bit_low(lo), .supply_enable_q(sup), .path_connect_q(path));
    asr_plc_model asr_plc_model_inst (.clock, .rstn, .sev_hi(hi),
        .sev_lo(lo), .cable_ok, .park_q(), .estop_q(estop));
    initial forever #12.5 clock = ~clock;
    task automatic tally_and_finish();
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Whole run is about 450 cycles
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic wcyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic t_states();
        logic [2:0] ph;
        `CHK("idle disp", `ASR_CH_DASH, disp)
        `CHK("idle pair", 2'b11, {hi, lo})
        unit_ready = 1'b1;
        wcyc(8);
        `CHK("ready disp", `ASR_CH_ZERO, disp)
        `CHK("ready path", 2'b11, {sup, path})
        `CHK("ready phase", 3'h0, rot)
        charging = 1'b1;
        wcyc(8);
        `CHK("chg disp", `ASR_CH_CW, disp)
        ph = rot;
        wcyc(8);
        `CHK("cw phase", ph + 3'h2, rot)
        discharging = 1'b1;
        wcyc(8);
        `CHK("dis disp", `ASR_CH_CCW, disp)
        ph = rot;
        wcyc(8);
        `CHK("ccw phase", ph - 3'h2, rot)
        charging = 1'b0;
        discharging = 1'b0;
    endtask
    task automatic t_alarms();
        for (int i = 0; i < 19; i++)
        begin
            fault_in = 19'h1 << i;
            wcyc(8);
            `CHK("code", exp_ch[i], disp)
            `CHK("pair", {i > 5, 1'b0}, {hi, lo})
            `CHK("supply", i == 17, sup)
            `CHK("path", i > 16, path)
            wcyc(4);
            `CHK("ctl stop", 1'b1, estop)
            fault_in = 19'h0;
            fault_clear = 1'b1;
            wcyc(8);
            `CHK("cleared", 2'b11, {hi, lo})
            fault_clear = 1'b0;
        end
    endtask
    task automatic t_refuse();
        fault_in = 19'h41;
        fault_clear = 1'b1;
        wcyc(8);
        `CHK("prio code", `ASR_CH_1, disp)
        `CHK("held pair", 2'b00, {hi, lo})
        fault_in = 19'h40;
        wcyc(8);
        `CHK("left code", `ASR_CH_7, disp)
        `CHK("set wins", 2'b10, {hi, lo})
        fault_in = 19'h0;
        wcyc(8);
        `CHK("all clear", 2'b11, {hi, lo})
        fault_clear = 1'b0;
    endtask
    task automatic t_cable();
        cable_ok = 1'b0;
        wcyc(3);
        `CHK("open cable", 1'b1, estop)
        cable_ok = 1'b1;
    endtask
    initial
    begin
        wcyc(5);
        rstn = 1'b1;
        wcyc(2);
        t_states();
        t_alarms();
        t_refuse();
        t_cable();
        tally_and_finish();
    end
endmodule
`default_nettype wire
